/* File: design/spi_frame_slave.sv */
// serial frame slave: 32-bit mode-0 link with frame checks and timeout
// assumes the host makes the serial clock; all pins are sampled on ref_clk
// and the register store outside answers reads combinationally

// Contract
// RULE1 - every frame is 32 bits, full duplex
// RULE2 - host uses clock polarity and phase zero
// RULE3 - capture on rising, change on falling edge
// RULE4 - output high impedance while deselected
// RULE5 - select timeout releases the output
// RULE6 - output shows error flag at select
// RULE7 - execute only after exactly 32 clocks
// RULE8 - execute only with valid count and address
// RULE9 - host keeps clock low at select edges
// RULE10 - msb first, next bits on falling edges
// RULE11 - host clock at most 4 MHz; the bench host model clocks at 8 MHz (125 ns period)
// RULE12 - opcode, address, three payload bytes, msb first
// RULE13 - decode write, read, clear, information
// RULE14 - write replaces register, returns old value
// RULE15 - read returns value, changes nothing
// RULE16 - clear bits whose payload bits are one
// RULE17 - opcode 11 all-ones address restores defaults
// RULE18 - opcode 10 all-ones address clears status
// RULE19 - load selected register into output shifter
// RULE20 - host clears only already reported bits
// RULE21 - no daisy chain, one select each
// RULE22 - status byte first, data at eighth edge
// RULE23 - top status bit is inverted OR
// RULE24 - information read: status, byte, then zeros
// RULE25 - timeout counted on core clock, parameter
module spi_frame_slave
    import spi_frame_pkg::*;
#(
    parameter int unsigned SELECT_TIMEOUT_NS = SELECT_TIMEOUT_NS_DEF
) (
    // core clock, reset and enable
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // serial link pins
    input  wire logic        chip_select_n,
    input  wire logic        serial_clock_pin,
    input  wire logic        serial_in_pin,
    output logic             serial_out,
    output logic             serial_out_oe,
    // register store side
    output logic [1:0]       access_op,
    output logic [5:0]       access_addr,
    input  wire logic [23:0] read_data,
    input  wire logic [7:0]  info_data,
    input  wire logic [6:0]  status_flags,
    input  wire logic        addr_valid,
    // end-of-frame commands
    output logic             exec_write,
    output logic             exec_clear,
    output logic             exec_defaults,
    output logic             exec_clear_all,
    output logic [5:0]       exec_addr,
    output logic [23:0]      exec_payload,
    output logic             frame_reject
);

    // timeout in core cycles, rounded up
    localparam int unsigned TIMEOUT_CYCLES =
        (SELECT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [23:0] TIMEOUT_CNT = 24'(TIMEOUT_CYCLES);

    // pin synchronisers and edge history
    logic        cs_meta, cs_sync, cs_prev;
    logic        sck_meta, sck_sync, sck_prev;
    logic        sdi_meta, sdi_sync;

    // frame state
    link_state_e state;         // link state
    logic [23:0] cs_cnt;        // cycles spent selected
    logic [5:0]  rise_cnt;      // rising clock edges seen, saturating
    logic [31:0] shift_in;      // incoming frame
    logic [4:0]  out_idx;       // bit index now on the output
    logic [7:0]  gsb_cap;       // status byte caught at select
    logic [23:0] data_cap;      // data word caught at eighth edge
    logic        load_req;      // pulse: first byte is in the shifter
    logic        load_dly;      // pulse: head held, load data word now
    logic [7:0]  head_cap;      // opcode and address after eighth edge

    // decoded edges and conditions
    wire         cs_fall    = cs_prev & ~cs_sync;
    wire         cs_rise    = ~cs_prev & cs_sync;
    wire         sck_rise   = ~cs_sync & ~sck_prev & sck_sync;
    wire         sck_fall   = ~cs_sync & sck_prev & ~sck_sync;
    wire         status_any = |status_flags;
    wire [1:0]   frame_op   = shift_in[OP_HI -: 2];
    wire [5:0]   frame_addr = shift_in[ADDR_HI -: 6];
    wire [23:0]  frame_pay  = shift_in[PAYLOAD_HI:0];
    wire         addr_all   = (frame_addr == ADDR_ALL);
    // RULE1 RULE7 exact clock count
    wire         count_ok   = (rise_cnt == FRAME_BITS);
    // RULE13 opcode decode
    wire         op_write   = (frame_op == OP_WRITE);
    wire         op_clear   = (frame_op == OP_RD_CLR);
    wire         op_info    = (frame_op == OP_INFO);
    wire         head_info  = (head_cap[7:6] == OP_INFO);
    // RULE8 RULE15 valid frames only, reads do nothing
    wire         do_write   = count_ok & op_write & addr_valid;
    wire         do_clr_all = count_ok & op_clear & addr_all;
    wire         do_clear   = count_ok & op_clear & ~addr_all & addr_valid;
    wire         do_dflt    = count_ok & op_info & addr_all;
    wire         bad_frame  = ~count_ok
                            | (op_write & ~addr_valid)
                            | (op_clear & ~addr_all & ~addr_valid);
    // RULE10 output bit select, status byte first
    wire         gsb_phase  = (out_idx >= GSB_LOW_IDX);
    wire [2:0]   gsb_idx    = 3'(out_idx - GSB_LOW_IDX);
    wire         out_bit    = gsb_phase ? gsb_cap[gsb_idx] : data_cap[out_idx];
    wire         any_exec   = exec_write | exec_clear
                            | exec_defaults | exec_clear_all;

    // the store sees opcode and address once the first byte is in
    assign access_op   = head_cap[7:6];
    assign access_addr = head_cap[5:0];

    // two-flop synchronisers, third flop only for edge history
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cs_meta  <= 1'b1;
            cs_sync  <= 1'b1;
            cs_prev  <= 1'b1;
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end else if (clk_en) begin
            cs_meta  <= chip_select_n;
            cs_sync  <= cs_meta;
            cs_prev  <= cs_sync;
            sck_meta <= serial_clock_pin;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
            sdi_meta <= serial_in_pin;
            sdi_sync <= sdi_meta;
        end
    end

    // link state and select timeout counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state  <= LINK_IDLE;
            cs_cnt <= 24'h0;
        end else if (clk_en) begin
            case (state)
                // waiting for select
                LINK_IDLE: begin
                    cs_cnt <= 24'h0;
                    if (cs_fall) begin
                        state <= LINK_FRAME;
                    end
                end
                // selected and driving
                LINK_FRAME: begin
                    cs_cnt <= cs_cnt + 24'h1;
                    if (cs_rise) begin
                        state <= LINK_IDLE;
                    // RULE25 timeout counted here
                    end else if (cs_cnt == TIMEOUT_CNT) begin
                        // RULE5 release after timeout
                        state <= LINK_TIMEOUT;
                    end
                end
                // still selected but released
                LINK_TIMEOUT: begin
                    if (cs_rise) begin
                        state <= LINK_IDLE;
                    end
                end
                default: state <= LINK_IDLE;
            endcase
        end
    end

    // input shifter and rising edge counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_in <= SHIFT_RST;
            rise_cnt <= 6'h0;
            load_req <= 1'b0;
            load_dly <= 1'b0;
            head_cap <= 8'h0;
        end else if (clk_en) begin
            load_req <= sck_rise & (rise_cnt == DATA_LOAD_CNT);
            load_dly <= load_req;
            // RULE22 first byte sits low in the shifter here
            if (load_req) begin
                head_cap <= shift_in[7:0];
            end
            if (cs_fall) begin
                rise_cnt <= 6'h0;
            // RULE3 capture on rising edge
            end else if (sck_rise) begin
                // RULE12 msb first into the frame
                shift_in <= {shift_in[30:0], sdi_sync};
                if (rise_cnt != CNT_SAT) begin
                    rise_cnt <= rise_cnt + 6'h1;
                end
            end
        end
    end

    // output word: status byte at select, data at eighth edge
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gsb_cap  <= GSB_RST;
            data_cap <= DATA_RST;
            out_idx  <= OUT_IDX_START;
        end else if (clk_en) begin
            if (cs_fall) begin
                // RULE23 top bit is the inverted OR
                gsb_cap <= {~status_any, status_flags};
                out_idx <= OUT_IDX_START;
            end else if (sck_fall && out_idx != 5'h0) begin
                // RULE10 next bit on falling edge
                out_idx <= out_idx - 5'h1;
            end
            // RULE19 load selected register
            if (load_dly) begin
                // RULE24 info byte then zeros
                data_cap <= head_info ? {info_data, INFO_PAD} : read_data;
            end
        end
    end

    // pin drivers, registered
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else if (clk_en) begin
            // RULE4 driver only in a live frame
            serial_out_oe <= (state == LINK_FRAME);
            // RULE6 status flag from select on
            serial_out    <= out_bit;
        end
    end

    // end-of-frame commands, one-cycle pulses
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exec_write     <= 1'b0;
            exec_clear     <= 1'b0;
            exec_defaults  <= 1'b0;
            exec_clear_all <= 1'b0;
            frame_reject   <= 1'b0;
            exec_addr      <= 6'h0;
            exec_payload   <= DATA_RST;
        end else if (clk_en) begin
            // RULE14 write at frame end
            exec_write     <= cs_rise & do_write;
            // RULE16 selective clear by payload mask
            exec_clear     <= cs_rise & do_clear;
            // RULE17 restore control defaults
            exec_defaults  <= cs_rise & do_dflt;
            // RULE18 clear every status register
            exec_clear_all <= cs_rise & do_clr_all;
            // RULE7 wrong count discards frame
            frame_reject   <= cs_rise & bad_frame;
            if (cs_rise) begin
                exec_addr    <= frame_addr;
                exec_payload <= frame_pay;
            end
        end
    end

    // checks run only while the block is enabled and out of reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || !clk_en);

    // frame end with a good clock count
    sequence frame_end_ok;
        cs_rise && count_ok;
    endsequence

    // frame end with a wrong clock count
    sequence frame_end_bad;
        cs_rise && !count_ok;
    endsequence

    // eighth rising edge followed by the load
    sequence eighth_edge;
        sck_rise && rise_cnt == DATA_LOAD_CNT ##1 load_req ##1 load_dly;
    endsequence

    oe_idle_a: assert property ( // RULE4
        cs_sync && state == LINK_IDLE |=> !serial_out_oe)
        else $error("output driven while deselected");

    timeout_off_a: assert property ( // RULE5
        state == LINK_TIMEOUT |=> !serial_out_oe)
        else $error("output driven after select timeout");

    error_flag_a: assert property ( // RULE6
        cs_fall |=> ##1 serial_out == !$past(status_any, 2) && serial_out_oe)
        else $error("select does not show the error flag");

    count_reject_a: assert property ( // RULE7
        frame_end_bad |=> frame_reject && !any_exec)
        else $error("bad clock count not rejected");

    write_exec_a: assert property ( // RULE14
        (frame_end_ok and (op_write && addr_valid)) |=>
        exec_write && exec_payload == $past(frame_pay)
        && exec_addr == $past(frame_addr))
        else $error("valid write not executed");

    bad_addr_a: assert property ( // RULE8
        (frame_end_ok and (op_write && !addr_valid)) |=>
        !exec_write && frame_reject)
        else $error("write to invalid address executed");

    read_quiet_a: assert property ( // RULE15
        cs_rise && frame_op == OP_READ |=> !any_exec)
        else $error("read frame changed state");

    clear_all_a: assert property ( // RULE18
        (frame_end_ok and (op_clear && addr_all)) |=>
        exec_clear_all && !exec_clear)
        else $error("clear all not executed");

    defaults_a: assert property ( // RULE17
        (frame_end_ok and (op_info && addr_all)) |=>
        exec_defaults && !exec_write)
        else $error("defaults command not executed");

    info_load_a: assert property ( // RULE24
        eighth_edge ##0 head_info |=> data_cap == {$past(info_data), INFO_PAD})
        else $error("information byte not loaded");

    shift_out_a: assert property ( // RULE10
        sck_fall && out_idx != 5'h0 |=> out_idx == $past(out_idx) - 5'h1)
        else $error("output index did not step on falling edge");

    gsb_top_a: assert property ( // RULE23
        cs_fall |=> gsb_cap[7] == !$past(status_any))
        else $error("status top bit is not the inverted OR");

endmodule

/* File: design/spi_frame_pkg.sv */
// constants shared by the serial frame slave interface
// assumes a single 125 MHz core clock that samples the serial link pins
package spi_frame_pkg;

    // core clock period and default select timeout
    localparam int unsigned CLK_PERIOD_NS         = 8;
    localparam int unsigned SELECT_TIMEOUT_NS_DEF = 40000;

    // frame length and bit counters
    localparam logic [5:0] FRAME_BITS    = 6'h20;
    localparam logic [5:0] DATA_LOAD_CNT = 6'h07;
    localparam logic [5:0] CNT_SAT       = 6'h3f;
    localparam logic [4:0] OUT_IDX_START = 5'h1f;
    localparam logic [4:0] GSB_LOW_IDX   = 5'h18;

    // field positions inside the 32-bit incoming frame
    localparam int unsigned OP_HI      = 31;
    localparam int unsigned ADDR_HI    = 29;
    localparam int unsigned PAYLOAD_HI = 23;

    // operation codes
    localparam logic [1:0] OP_WRITE  = 2'h0;
    localparam logic [1:0] OP_READ   = 2'h1;
    localparam logic [1:0] OP_RD_CLR = 2'h2;
    localparam logic [1:0] OP_INFO   = 2'h3;

    // all-ones address selects the advanced operations
    localparam logic [5:0] ADDR_ALL = 6'h3f;

    // reset values
    localparam logic [31:0] SHIFT_RST = 32'h0;
    localparam logic [23:0] DATA_RST  = 24'h0;
    localparam logic [7:0]  GSB_RST   = 8'h0;
    localparam logic [15:0] INFO_PAD  = 16'h0;

    // link state
    typedef enum logic [1:0] {LINK_IDLE, LINK_FRAME, LINK_TIMEOUT} link_state_e;

endpackage

/* File: test/spi_host_model.sv */
// host model: drives select, serial clock and data in, mode 0
// assumes the bench calls frame() or hold() and reads serial_out back
module spi_host_model (
    // link pins
    output logic      chip_select_n,
    output logic      sck,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle link: deselected, clock low
    initial begin
        chip_select_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end

    // one frame of n clocks at a 125 ns clock period
    task automatic frame(input logic [31:0] tx, input int n,
                         output logic [31:0] rx);
        rx = 32'h0;
        // own select, clock low at select edges
        chip_select_n = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            // msb first, data changes on falling edge
            sdi = tx[31 - (i % 32)];
            #62.5 sck = 1'b1;
            rx = {rx[30:0], sdo};
            // clock idles low, 8 MHz from the 125 ns period
            #62.5 sck = 1'b0;
        end
        #200 chip_select_n = 1'b1;
        // released data line shows the inverse of its last value
        sdi = ~sdi;
        #500;
    endtask

    // select held low with no clock at all
    task automatic hold(input int ns);
        chip_select_n = 1'b0;
        #ns chip_select_n = 1'b1;
        #500;
    endtask
endmodule

/* File: test/spi_frame_slave_interface_tb_top.sv */
// bench for the serial frame slave: host model, store stand-in, checks
// assumes a 125 MHz core clock and a host clock of 125 ns period
module spi_frame_slave_interface_tb_top import spi_frame_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    // core side
    logic        ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    // link pins
    logic        chip_select_n, serial_clock_pin, serial_in_pin;
    logic        serial_out, serial_out_oe;
    // a released line reads as the inverse of the last bit driven
    wire         sdo_line = serial_out_oe ? serial_out : ~serial_out;
    // store side
    logic [1:0]  access_op;
    logic [5:0]  access_addr, exec_addr;
    logic [23:0] read_data, exec_payload;
    logic [7:0]  info_data;
    logic [6:0]  status_flags = 7'h0;
    logic        addr_valid = 1'b0;
    logic        exec_write, exec_clear, exec_defaults, exec_clear_all;
    logic        frame_reject;
    // {write, clear, defaults, clear_all, reject} seen since last clear
    logic [4:0]  seen;
    logic [29:0] got_cmd;
    int          miscompares = 0, check_count = 0;

    // 8 ns core clock
    always #4 ref_clk = ~ref_clk;

    // store answers derived from the address
    assign read_data = {2'h0, access_addr, 16'hc35a};
    assign info_data = {2'h2, access_addr};

    // collect end-of-frame pulses and their arguments
    always @(posedge ref_clk) begin
        if (exec_write | exec_clear) got_cmd <= {exec_addr, exec_payload};
        seen <= seen | {exec_write, exec_clear, exec_defaults,
                        exec_clear_all, frame_reject};
    end

    spi_frame_slave #(.SELECT_TIMEOUT_NS(8000)) i_dut (
        .ref_clk, .sys_rst, .clk_en, .chip_select_n, .serial_clock_pin,
        .serial_in_pin, .serial_out, .serial_out_oe, .access_op,
        .access_addr, .read_data, .info_data, .status_flags, .addr_valid,
        .exec_write, .exec_clear, .exec_defaults, .exec_clear_all,
        .exec_addr, .exec_payload, .frame_reject);

    spi_host_model i_host (.chip_select_n, .sck(serial_clock_pin),
                           .sdi(serial_in_pin), .sdo(sdo_line));

    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // compare one value
    task automatic check(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one frame: judges end-of-frame command, and the reply word when n is 32
    task automatic run(input string name, input logic [31:0] tx,
                       input int n, input logic [6:0] flags,
                       input logic ok, input logic [4:0] exp);
        logic [31:0] rx, want;
        @(posedge ref_clk) #1;
        status_flags = flags;
        addr_valid = ok;
        seen = 5'h0;
        i_host.frame(tx, n, rx);
        want = {~|flags, flags, (tx[31:30] == OP_INFO) ?
                {2'h2, tx[29:24], 16'h0} : {2'h0, tx[29:24], 16'hc35a}};
        check({name, " cmd"}, 32'(exp), 32'(seen));
        check({name, " head"}, {24'h0, tx[31:24]},
              {24'h0, access_op, access_addr});
        if (exp[4] | exp[3])
            check({name, " args"}, {2'h0, tx[29:0]}, {2'h0, got_cmd});
        if (n == 32)
            check({name, " reply"}, want, rx);
        check({name, " oe idle"}, 32'h0, 32'(serial_out_oe));
        $display("test %s done", name);
    endtask

    // select held low without clocks: output released, frame refused
    task automatic timeout_test;
        int j;
        int k;
        @(posedge ref_clk) #1;
        seen = 5'h0;
        fork
            i_host.hold(9000);
            begin
                for (j = 0; j < 20 && serial_out_oe !== 1'b1; j++)
                    @(posedge ref_clk) #1;
                for (k = 0; k < 1100 && serial_out_oe === 1'b1; k++)
                    @(posedge ref_clk) #1;
                if (k == 1100) begin
                    miscompares++;
                    end_of_test();
                end else
                    check("oe time", 32'h1, 32'(k >= 998 && k <= 1002));
            end
        join
        check("timeout cmd", 32'h1, 32'(seen));
        $display("test timeout done");
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check("reset", 32'h0, {1'b0, serial_out_oe, exec_addr, exec_payload});
        run("read", {OP_READ, 6'h05, 24'hffffff}, 32, 7'h00, 1, 5'h00);
        run("write", {OP_WRITE, 6'h02, 24'h123456}, 32, 7'h05, 1, 5'h10);
        run("bad addr", {OP_WRITE, 6'h00, 24'h0000ff}, 32, 7'h00, 0, 5'h01);
        run("clear", {OP_RD_CLR, 6'h31, 24'h000081}, 32, 7'h40, 1, 5'h08);
        run("clear all", {OP_RD_CLR, ADDR_ALL, 24'h0}, 32, 7'h00, 1, 5'h02);
        run("defaults", {OP_INFO, ADDR_ALL, 24'h0}, 32, 7'h12, 1, 5'h04);
        run("info", {OP_INFO, 6'h0a, 24'h0}, 32, 7'h00, 1, 5'h00);
        run("short", {OP_WRITE, 6'h02, 24'h00aa55}, 31, 7'h00, 1, 5'h01);
        run("long", {OP_WRITE, 6'h02, 24'h00aa55}, 33, 7'h00, 1, 5'h01);
        timeout_test();
        end_of_test();
    end
endmodule
